// File: src/charger_defines.vh
// Constants for the charger control sequencer
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

// ****************************************
// Clock and timebase
// ****************************************
`define CLK_PERIOD_NS 8
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES_DEF ((`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Safety and taper limits in timebase ticks
// ****************************************
`define PRECHG_TIME_TICKS 32'h001B7740
`define FAST_TIME_TICKS 32'h00FFFFFF
`define TAPER_TIME_TICKS 32'h001B7740

// ****************************************
// Sequencer states
// ****************************************
`define ST_SLEEP 3'h0
`define ST_OFF 3'h1
`define ST_PRE 3'h2
`define ST_FAST 3'h3
`define ST_DONE 3'h4
`define ST_FAULT 3'h5

// ****************************************
// Register byte addresses
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_RESTART_BIT 0
`define CTRL_INHIBIT_BIT 1
`define IRQ_FAULT_BIT 0
`define IRQ_DONE_BIT 1
`define IRQ_SUSPEND_BIT 2
`define IRQ_SLEEP_BIT 3
`define IRQ_MASK_RST 4'h0
`define CTRL_INHIBIT_RST 1'b0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: src/input_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] ff1_r;
  reg [WIDTH-1:0] ff2_r;
  reg [WIDTH-1:0] ff3_r;

  // Output follows only bits where stages two and three agree
  always @(posedge mclk) begin
    if (rst) begin
      ff1_r <= INIT;
      ff2_r <= INIT;
      ff3_r <= INIT;
      dout <= INIT;
    end else begin
      ff1_r <= din;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      dout <= (ff3_r & ~(ff2_r ^ ff3_r)) | (dout & (ff2_r ^ ff3_r));
    end
  end

endmodule

`default_nettype wire

// File: src/charger_control_sequencer.v
// Charge control sequencer with AXI4-Lite registers and interrupt
// Contract
// - Adapter-good indication driven on while adapter comparator reports valid supply.
// - Adapter-good indication released while in sleep mode.
// - Enable low permits charging; enable high stops charging into low-power state.
// - Enable falling edge resets all charge timers and clears timer faults.
// - Timer-taper enable low runs fast and taper timers; high disables both.
// - Fast-timer-enable variant gates only the shared precharge and fast-charge safety timer.
// - Junction over-limit suspends charging until cooled about 15 degrees below.
// - Fault above recharge threshold waits for battery to drop, then restarts.
// - Reset or toggling either enable input clears a latched timer fault; with HAS_FAST_TE set, only toggling charge enable clears it.
// - Fault below recharge threshold turns probe current on while below.
// - Battery rising above threshold drops probe, then follows above-threshold recovery.
// - Two open-drain status outputs encode precharge, fast, done, else both off.
// - Battery temperature out of window suspends charging, holding timers unreset.
// - Safety timer expiring before termination turns charger off, reports fault.
// - Both supplies absent puts the device into sleep mode.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"

module charger_control_sequencer #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES_DEF,
  parameter [31:0] PRECHG_TICKS = `PRECHG_TIME_TICKS,
  parameter [31:0] FAST_TICKS = `FAST_TIME_TICKS,
  parameter [31:0] TAPER_TICKS = `TAPER_TIME_TICKS,
  parameter HAS_FAST_TE = 0
) (
  input wire mclk,
  input wire rst,
  input wire adapter_ok,
  input wire usb_ok,
  input wire charge_enable_n,
  input wire timer_taper_enable_n,
  input wire fast_timer_enable_n,
  input wire junction_over,
  input wire junction_cooled,
  input wire batt_temp_ok,
  input wire batt_above_rch,
  input wire batt_above_lowv,
  input wire taper_detect,
  input wire term_detect,
  output reg adapter_good_n_o,
  output reg adapter_good_n_oe_n,
  output reg charge_state_a_o,
  output reg charge_state_a_oe_n,
  output reg charge_state_b_o,
  output reg charge_state_b_oe_n,
  output reg power_switch_on,
  output reg fault_probe_on,
  output reg irq,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] bump;
    input [31:0] cnt;
    begin
      bump = (cnt == 32'hFFFFFFFF) ? cnt : cnt + 32'h00000001;
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      case ({addr[7:2], 2'b00})
        `REG_CTRL, `REG_STATUS, `REG_IRQ_STAT, `REG_IRQ_MASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  wire [11:0] sync_w;
  wire adapter_s;
  wire usb_s;
  wire ce_n_s;
  wire tte_n_s;
  wire te_n_s;
  wire jover_s;
  wire jcool_s;
  wire btemp_s;
  wire above_rch_s;
  wire above_lowv_s;
  wire taper_s;
  wire term_s;
  reg ce_n_d_r;
  reg tte_n_d_r;
  reg thermal_hold_r;
  reg susp_d_r;
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [31:0] chg_cnt_r;
  reg [31:0] taper_cnt_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg fault_high_r;
  reg fault_high_nxt;
  reg ctrl_restart_r;
  reg ctrl_inhibit_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;
  reg [7:0] aw_addr_r;
  reg aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_have_r;
  reg [31:0] rd_mux;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  input_sync #(
    .WIDTH(12),
    .INIT(12'h00C)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({term_detect, taper_detect, batt_above_lowv, batt_above_rch,
      batt_temp_ok, junction_cooled, junction_over, fast_timer_enable_n,
      timer_taper_enable_n, charge_enable_n, usb_ok, adapter_ok}),
    .dout(sync_w)
  );

  assign adapter_s = sync_w[0];
  assign usb_s = sync_w[1];
  assign ce_n_s = sync_w[2];
  assign tte_n_s = sync_w[3];
  assign te_n_s = sync_w[4];
  assign jover_s = sync_w[5];
  assign jcool_s = sync_w[6];
  assign btemp_s = sync_w[7];
  assign above_rch_s = sync_w[8];
  assign above_lowv_s = sync_w[9];
  assign taper_s = sync_w[10];
  assign term_s = sync_w[11];

  // ****************************************
  // Qualifiers
  // ****************************************
  wire ce_fall = ce_n_d_r & ~ce_n_s;
  wire tte_tog = (HAS_FAST_TE == 0) & (tte_n_d_r ^ tte_n_s);
  wire restart = ce_fall | tte_tog | ctrl_restart_r;
  wire fast_tmr_en = (HAS_FAST_TE != 0) ? ~te_n_s : ~tte_n_s;
  wire taper_en = (HAS_FAST_TE != 0) ? 1'b1 : ~tte_n_s;
  wire suspended = thermal_hold_r | ~btemp_s;
  wire sleep_req = ~adapter_s & ~usb_s;
  wire enable = ~ce_n_s & ~ctrl_inhibit_r;
  wire in_chg = (state_r == `ST_PRE) | (state_r == `ST_FAST);
  wire [31:0] chg_limit = (state_r == `ST_PRE) ? PRECHG_TICKS : FAST_TICKS;
  wire chg_expired = fast_tmr_en & ~suspended & (chg_cnt_r >= chg_limit);
  wire taper_done = taper_en & taper_s & (taper_cnt_r >= TAPER_TICKS);
  wire [2:0] start_st = above_lowv_s ? `ST_FAST : `ST_PRE;

  always @(posedge mclk) begin
    if (rst) begin
      ce_n_d_r <= 1'b1;
      tte_n_d_r <= 1'b1;
      thermal_hold_r <= 1'b0;
      susp_d_r <= 1'b0;
    end else begin
      ce_n_d_r <= ce_n_s;
      tte_n_d_r <= tte_n_s;
      susp_d_r <= suspended;
      if (jover_s) begin
        thermal_hold_r <= 1'b1;
      end else if (jcool_s) begin
        thermal_hold_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Timebase and charge timers
  // ****************************************
  always @(posedge mclk) begin
    if (rst) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 32'h00000001) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (rst || restart || state_nxt != state_r) begin
      chg_cnt_r <= 32'h00000000;
      taper_cnt_r <= 32'h00000000;
    end else begin
      if (!fast_tmr_en) begin
        chg_cnt_r <= 32'h00000000;
      end else if (tick_r && in_chg && !suspended) begin
        chg_cnt_r <= bump(chg_cnt_r);
      end
      if (!taper_en || !taper_s) begin
        taper_cnt_r <= 32'h00000000;
      end else if (tick_r && state_r == `ST_FAST && !suspended) begin
        taper_cnt_r <= bump(taper_cnt_r);
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_nxt = state_r;
    fault_high_nxt = fault_high_r;
    if (sleep_req) begin
      state_nxt = `ST_SLEEP;
    end else if (!enable) begin
      state_nxt = `ST_OFF;
    end else begin
      case (state_r)
        `ST_SLEEP, `ST_OFF: begin
          state_nxt = start_st;
        end
        `ST_PRE, `ST_FAST: begin
          if (chg_expired) begin
            state_nxt = `ST_FAULT;
            fault_high_nxt = above_rch_s;
          end else if (!suspended && state_r == `ST_PRE && above_lowv_s) begin
            state_nxt = `ST_FAST;
          end else if (!suspended && state_r == `ST_FAST && (term_s || taper_done)) begin
            state_nxt = `ST_DONE;
          end
        end
        `ST_DONE: begin
          if (!above_rch_s) begin
            state_nxt = start_st;
          end
        end
        `ST_FAULT: begin
          if (restart) begin
            state_nxt = start_st;
          end else if (fault_high_r && !above_rch_s) begin
            state_nxt = start_st;
          end else if (!fault_high_r && above_rch_s) begin
            fault_high_nxt = 1'b1;
          end
        end
        default: begin
          state_nxt = `ST_SLEEP;
        end
      endcase
    end
  end

  wire chg_nxt = ((state_nxt == `ST_PRE) | (state_nxt == `ST_FAST)) & ~suspended;
  wire stat_a_on = chg_nxt;
  wire stat_b_on = (chg_nxt & (state_nxt == `ST_PRE)) | (state_nxt == `ST_DONE);

  always @(posedge mclk) begin
    if (rst) begin
      state_r <= `ST_SLEEP;
      fault_high_r <= 1'b0;
      adapter_good_n_o <= 1'b0;
      adapter_good_n_oe_n <= 1'b1;
      charge_state_a_o <= 1'b0;
      charge_state_a_oe_n <= 1'b1;
      charge_state_b_o <= 1'b0;
      charge_state_b_oe_n <= 1'b1;
      power_switch_on <= 1'b0;
      fault_probe_on <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fault_high_r <= fault_high_nxt;
      adapter_good_n_oe_n <= ~(adapter_s & (state_nxt != `ST_SLEEP));
      charge_state_a_oe_n <= ~stat_a_on;
      charge_state_b_oe_n <= ~stat_b_on;
      power_switch_on <= chg_nxt;
      fault_probe_on <= (state_nxt == `ST_FAULT) & ~fault_high_nxt & ~above_rch_s;
    end
  end

  // ****************************************
  // Interrupt status and output
  // ****************************************
  wire [3:0] ev;
  assign ev[`IRQ_FAULT_BIT] = (state_nxt == `ST_FAULT) & (state_r != `ST_FAULT);
  assign ev[`IRQ_DONE_BIT] = (state_nxt == `ST_DONE) & (state_r != `ST_DONE);
  assign ev[`IRQ_SUSPEND_BIT] = in_chg & suspended & ~susp_d_r;
  assign ev[`IRQ_SLEEP_BIT] = (state_nxt == `ST_SLEEP) & (state_r != `ST_SLEEP);

  wire wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [7:0] wr_word = {aw_addr_r[7:2], 2'b00};
  wire wr_lo = wr_fire & w_strb_r[0];
  wire [3:0] w1c = (wr_lo && wr_word == `REG_IRQ_STAT) ? w_data_r[3:0] : 4'h0;

  always @(posedge mclk) begin
    if (rst) begin
      irq_stat_r <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  always @(posedge mclk) begin
    if (rst) begin
      aw_addr_r <= 8'h00;
      aw_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_restart_r <= 1'b0;
      ctrl_inhibit_r <= `CTRL_INHIBIT_RST;
      irq_mask_r <= `IRQ_MASK_RST;
    end else begin
      ctrl_restart_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_have_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_have_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_lo && wr_word == `REG_CTRL) begin
          ctrl_restart_r <= w_data_r[`CTRL_RESTART_BIT];
          ctrl_inhibit_r <= w_data_r[`CTRL_INHIBIT_BIT];
        end
        if (wr_lo && wr_word == `REG_IRQ_MASK) begin
          irq_mask_r <= w_data_r[3:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always @* begin
    rd_mux = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'b00})
      `REG_CTRL: rd_mux = {30'h00000000, ctrl_inhibit_r, 1'b0};
      `REG_STATUS: rd_mux = {24'h000000, fast_tmr_en, power_switch_on,
        fault_probe_on, thermal_hold_r, suspended, state_r};
      `REG_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_r};
      `REG_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: dv/charger_control_sequencer_sva.sv
// Pin-level assertions for the charger sequencer
`timescale 1ns/1ps
`default_nettype none
module charger_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic adapter_ok,
  input wire logic usb_ok,
  input wire logic charge_enable_n,
  input wire logic junction_over,
  input wire logic batt_temp_ok,
  input wire logic batt_above_rch,
  input wire logic adapter_good_n_oe_n,
  input wire logic charge_state_a_oe_n,
  input wire logic charge_state_b_oe_n,
  input wire logic power_switch_on,
  input wire logic fault_probe_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Inputs held long enough to pass the synchroniser
  sequence s_no_supply;
    (!adapter_ok && !usb_ok) [*8];
  endsequence
  sequence s_adapter;
    adapter_ok [*8];
  endsequence
  property p_pg_on;
    s_adapter |-> ##[0:4] !adapter_good_n_oe_n;
  endproperty
  a_pg_on: assert property (p_pg_on)
    else $error("adapter good not on with adapter present");
  property p_sleep;
    s_no_supply |-> ##[0:4] (adapter_good_n_oe_n && !power_switch_on);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered with both supplies gone");
  property p_ce_off;
    charge_enable_n [*8] |-> ##[0:4] !power_switch_on;
  endproperty
  a_ce_off: assert property (p_ce_off)
    else $error("charging with enable high");
  property p_junction;
    junction_over [*8] |-> ##[0:4] !power_switch_on;
  endproperty
  a_junction: assert property (p_junction)
    else $error("charging while junction hot");
  property p_batt_temp;
    !batt_temp_ok [*8] |-> ##[0:4] !power_switch_on;
  endproperty
  a_batt_temp: assert property (p_batt_temp)
    else $error("charging with battery temperature out of window");
  property p_probe_drop;
    batt_above_rch [*8] |-> ##[0:4] !fault_probe_on;
  endproperty
  a_probe_drop: assert property (p_probe_drop)
    else $error("probe current on above recharge threshold");
  property p_probe_fault;
    fault_probe_on |-> (!power_switch_on && charge_state_a_oe_n && charge_state_b_oe_n);
  endproperty
  a_probe_fault: assert property (p_probe_fault)
    else $error("probe current on outside fault state");
  property p_state_a;
    !charge_state_a_oe_n |-> power_switch_on;
  endproperty
  a_state_a: assert property (p_state_a)
    else $error("charge status shown with switch off");
  property p_done;
    (charge_state_a_oe_n && !charge_state_b_oe_n) |-> !power_switch_on;
  endproperty
  a_done: assert property (p_done)
    else $error("done status with switch on");
endmodule
`default_nettype wire

// File: dv/charger_pins_model.sv
// Host side of the open-drain status pins, with pull-ups
`timescale 1ns/1ps
`default_nettype none
module charger_pins_model (
  input wire logic adapter_good_n_o,
  input wire logic adapter_good_n_oe_n,
  input wire logic charge_state_a_o,
  input wire logic charge_state_a_oe_n,
  input wire logic charge_state_b_o,
  input wire logic charge_state_b_oe_n,
  output logic pg_pin,
  output logic sa_pin,
  output logic sb_pin
);
  // Released pin floats high through the pull-up
  assign pg_pin = adapter_good_n_oe_n ? 1'b1 : adapter_good_n_o;
  assign sa_pin = charge_state_a_oe_n ? 1'b1 : charge_state_a_o;
  assign sb_pin = charge_state_b_oe_n ? 1'b1 : charge_state_b_o;
endmodule
`default_nettype wire

// File: dv/test_charger_control_sequencer.sv
// Self-checking testbench for the charger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"
module test_charger_control_sequencer;
  logic mclk, rst, adapter_ok, usb_ok, charge_enable_n, timer_taper_enable_n;
  logic fast_timer_enable_n, junction_over, junction_cooled, batt_temp_ok;
  logic batt_above_rch, batt_above_lowv, taper_detect, term_detect, smp;
  logic adapter_good_n_o, adapter_good_n_oe_n, charge_state_a_o, charge_state_a_oe_n;
  logic charge_state_b_o, charge_state_b_oe_n, power_switch_on, fault_probe_on, irq;
  logic pg_pin, sa_pin, sb_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  logic [33:0] wr_q[$], rd_q[$], pin_q[$];
  logic [31:0] rm_q[$];
  wire [5:0] pv = {pg_pin, sa_pin, sb_pin, power_switch_on, fault_probe_on, irq};

  charger_control_sequencer #(.TICK_CYCLES(32'h4), .PRECHG_TICKS(32'h14),
    .FAST_TICKS(32'h28), .TAPER_TICKS(32'hA), .HAS_FAST_TE(0)) DUT (.*);
  charger_pins_model host (.adapter_good_n_o(adapter_good_n_o),
    .adapter_good_n_oe_n(adapter_good_n_oe_n), .charge_state_a_o(charge_state_a_o),
    .charge_state_a_oe_n(charge_state_a_oe_n), .charge_state_b_o(charge_state_b_o),
    .charge_state_b_oe_n(charge_state_b_oe_n), .pg_pin(pg_pin), .sa_pin(sa_pin),
    .sb_pin(sb_pin));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (s_axi_bvalid && s_axi_bready)
      check({32'h0, s_axi_bresp}, wr_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata & rm_q.pop_front()}, rd_q.pop_front());
    if (smp)
      check({28'h0, pv}, pin_q.pop_front());
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    wr_q.push_back({32'h0, e});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
    rd_q.push_back(e);
    rm_q.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask

  // Wait a bounded time for the pins, then note and sample them
  task automatic pins(input logic [5:0] e, input int tmo);
    int i;
    for (i = 0; i < tmo && pv !== e; i++)
      @(posedge mclk);
    pin_q.push_back({28'h0, e});
    smp <= 1'b1;
    @(posedge mclk);
    smp <= 1'b0;
  endtask

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    rst = 1'b1;
    adapter_ok = 1'b1;
    usb_ok = 1'b0;
    charge_enable_n = 1'b0;
    timer_taper_enable_n = 1'b0;
    fast_timer_enable_n = 1'b0;
    junction_over = 1'b0;
    junction_cooled = 1'b1;
    batt_temp_ok = 1'b1;
    batt_above_rch = 1'b0;
    batt_above_lowv = 1'b0;
    taper_detect = 1'b0;
    term_detect = 1'b0;
    smp = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    void'($urandom(56883));
    tick(3);
    rst <= 1'b0;
    usb_ok <= 1'($urandom_range(1, 0));
    tick(2);
    axi_rd(`REG_IRQ_MASK, 32'hFF, 34'h0);
    pins(6'h04, 100);
    $display("test precharge done");
    pins(6'h1A, 300);
    axi_rd(`REG_STATUS, 32'hFFFFFF7F, {`RESP_OKAY, 32'h25});
    axi_rd(`REG_IRQ_STAT, 32'h1, {`RESP_OKAY, 32'h1});
    axi_wr(`REG_IRQ_MASK, {24'($urandom), 8'h01}, `RESP_OKAY);
    pins(6'h1B, 10);
    axi_wr(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
    pins(6'h1A, 10);
    axi_wr(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
    axi_rd(8'h10, 32'hFFFFFFFF, {`RESP_SLVERR, 32'h0});
    axi_wr(8'h14, 32'h3, `RESP_SLVERR);
    $display("test fault below threshold done");
    batt_above_lowv <= 1'b1;
    batt_above_rch <= 1'b1;
    pins(6'h18, 50);
    batt_above_rch <= 1'b0;
    pins(6'h0C, 50);
    $display("test probe recovery done");
    junction_over <= 1'b1;
    junction_cooled <= 1'b0;
    pins(6'h18, 50);
    tick(4);
    junction_over <= 1'b0;
    tick(20);
    pins(6'h18, 0);
    junction_cooled <= 1'b1;
    pins(6'h0C, 50);
    batt_temp_ok <= 1'b0;
    pins(6'h18, 50);
    tick(4);
    batt_temp_ok <= 1'b1;
    pins(6'h0C, 50);
    $display("test suspend done");
    batt_above_rch <= 1'b1;
    pins(6'h18, 400);
    axi_rd(`REG_STATUS, 32'h7, {`RESP_OKAY, 32'h5});
    timer_taper_enable_n <= 1'b1;
    pins(6'h0C, 50);
    tick(250);
    pins(6'h0C, 0);
    term_detect <= 1'b1;
    pins(6'h10, 50);
    $display("test timer disable done");
    charge_enable_n <= 1'b1;
    pins(6'h18, 50);
    term_detect <= 1'b0;
    timer_taper_enable_n <= 1'b0;
    tick(10);
    charge_enable_n <= 1'b0;
    pins(6'h0C, 50);
    pins(6'h18, 400);
    charge_enable_n <= 1'b1;
    tick(10);
    charge_enable_n <= 1'b0;
    pins(6'h0C, 50);
    tick(100);
    pins(6'h0C, 0);
    charge_enable_n <= 1'b1;
    @(posedge mclk);
    charge_enable_n <= 1'b0;
    tick(10);
    pins(6'h0C, 0);
    $display("test enable recovery done");
    batt_above_rch <= 1'b0;
    adapter_ok <= 1'b0;
    usb_ok <= 1'b0;
    pins(6'h38, 50);
    usb_ok <= 1'b1;
    pins(6'h2C, 50);
    $display("test sleep done");
    end_of_test();
  end
endmodule

bind charger_control_sequencer charger_checker chk (.*);
`default_nettype wire
